/* hdl/adp_device.sv */
// Device end: control register access, ancillary loading and pin mapping
//
// Overview of operation
// - Low eight lines data, upper two qualifiers
// - Host marks address words with 00
// - Host marks write data words with 11
// - Read data returned marked with 10
// - Three port clocks after reset before access
// - Path low, direction high selects read
// - Address taken at port clock rising edge
// - Read data driven until next rising edge
// - Host releases bus right after read address
// - Both selects low: address then data clock
// - Write data stored at second rising edge
// - Host removes write words by falling edge
// - Path high, direction low loads FIFO words
// - FIFO write only, never read back
// - Host loads during active video, H pin
// - Host sends packet words starting with DID
// - Device appends checksum unless host supplies
// - Device prefixes each packet with flag
// - Two extra clocks flush the last packet
// - Insertion area depends on video definition
// - Eight six-bit maps tie bits to pins
// - Pin inputs taken on port clock only
// - Port clock no faster than video clock
`include "adp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adp_device (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  adp_link_if.device       link,
  input  wire logic [7:0]  fieldErrorFlags,
  input  wire logic [31:0] statusBits,
  input  wire logic [7:0]  ioPinIn,
  input  wire logic        hostSuppliesChecksum,
  output logic [31:0]      controlBits,
  output logic [7:0]       testPatternSetup,
  output logic [9:0]       ancWord,
  output logic             ancValid,
  output logic             ancPacketStart
);
  adp_pkg::adp_ctl_state_t ctlState;
  adp_pkg::adp_anc_phase_t ancPhase;
  logic [20:0] syncA, syncB, syncC, linkSt, next_linkSt;
  logic        aclkRise;
  logic        pathSel;
  logic        rdWr;
  logic [9:0]  busIn;
  logic [7:0]  pinInSt;
  logic        ancMode;
  logic [1:0]  initCnt;
  logic        portReady;
  logic [7:0]  ctlAddr;
  logic [7:0]  regFile [256];
  logic [5:0]  pinMap [8];
  logic [7:0]  ctrlReg [4];
  logic [7:0]  readData;
  logic [7:0]  pinOff;
  logic [7:0]  ctrlOff;
  logic [7:0]  wrPinOff;
  logic [7:0]  wrCtrlOff;
  logic [9:0]  pipe0, pipe1, pendWord, ancIn;
  logic        pipe0V, pipe1V, pipe0Did, pipe1Did;
  logic [8:0]  csum;
  logic [7:0]  udwLeft;
  logic [2:0]  emitCnt;
  logic        pushNow;

  // ****************************************
  // Link input synchroniser
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA  <= 21'h000000;
      syncB  <= 21'h000000;
      syncC  <= 21'h000000;
      linkSt <= 21'h000000;
    end else begin
      syncA  <= {ioPinIn, link.aclk, link.pathSelect, link.readWriteSelect, link.adBus};
      syncB  <= syncA;
      syncC  <= syncB;
      linkSt <= next_linkSt;
    end
  end

  // A bit changes once stages two and three agree
  assign next_linkSt = (syncB & syncC) | (linkSt & (syncB | syncC));
  assign aclkRise    = next_linkSt[12] & ~linkSt[12];
  assign pathSel     = next_linkSt[11];
  assign rdWr        = next_linkSt[10];
  assign busIn       = next_linkSt[9:0];
  assign pinInSt     = next_linkSt[20:13];
  assign ancMode     = pathSel & ~rdWr;
  assign portReady   = initCnt == `ADP_INIT_PULSES;

  // Port stays deaf until three clocks after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      initCnt <= 2'h0;
    end else if (aclkRise && !portReady) begin
      initCnt <= initCnt + 2'h1;
    end
  end

  // ****************************************
  // Register read selection
  // ****************************************
  always_comb begin
    pinOff  = busIn[7:0] - `ADP_REG_PIN_MAP0;
    ctrlOff = busIn[7:0] - `ADP_REG_CTRL_BASE;
    if (busIn[7:0] == `ADP_REG_FIELD_FLAGS) begin
      readData = fieldErrorFlags;
    end else if (busIn[7:0] >= `ADP_REG_PIN_MAP0 && busIn[7:0] <= `ADP_REG_PIN_MAP_LAST) begin
      readData = {2'h0, pinMap[pinOff[2:0]]};
    end else if (busIn[7:0] >= `ADP_REG_CTRL_BASE && busIn[7:0] <= `ADP_REG_CTRL_LAST) begin
      readData = ctrlReg[ctrlOff[1:0]];
    end else begin
      readData = regFile[busIn[7:0]];
    end
  end

  // ****************************************
  // Control access sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctlState     <= adp_pkg::CS_IDLE;
      ctlAddr      <= 8'h00;
      link.devBus   <= 10'h000;
      link.devBusOe <= 1'b0;
    end else if (aclkRise && portReady) begin
      case (ctlState)
        adp_pkg::CS_DRIVE: begin
          link.devBusOe <= 1'b0;
          ctlState      <= adp_pkg::CS_IDLE;
        end
        adp_pkg::CS_WDATA: begin
          ctlState <= adp_pkg::CS_IDLE;
        end
        default: begin
          if (!pathSel && busIn[9:8] == `ADP_QUAL_ADDR) begin
            ctlAddr <= busIn[7:0];
            if (rdWr) begin
              link.devBus   <= {`ADP_QUAL_RDATA, readData};
              link.devBusOe <= 1'b1;
              ctlState      <= adp_pkg::CS_DRIVE;
            end else begin
              ctlState <= adp_pkg::CS_WDATA;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Register storage and pin input capture
  // ****************************************
  assign wrPinOff  = ctlAddr - `ADP_REG_PIN_MAP0;
  assign wrCtrlOff = ctlAddr - `ADP_REG_CTRL_BASE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        regFile[i] <= 8'h00;
      end
      for (int i = 0; i < 8; i++) begin
        pinMap[i] <= `ADP_PIN_MAP_RESET0 + 6'(i);
      end
      for (int i = 0; i < 4; i++) begin
        ctrlReg[i] <= 8'h00;
      end
    end else if (aclkRise && portReady) begin
      if (ctlState == adp_pkg::CS_WDATA && !pathSel && !rdWr
          && busIn[9:8] == `ADP_QUAL_WDATA) begin
        if (ctlAddr == `ADP_REG_FIELD_FLAGS) begin
          regFile[ctlAddr] <= regFile[ctlAddr];
        end else if (ctlAddr >= `ADP_REG_PIN_MAP0 && ctlAddr <= `ADP_REG_PIN_MAP_LAST) begin
          pinMap[wrPinOff[2:0]] <= busIn[5:0];
        end else if (ctlAddr >= `ADP_REG_CTRL_BASE && ctlAddr <= `ADP_REG_CTRL_LAST) begin
          ctrlReg[wrCtrlOff[1:0]] <= busIn[7:0];
        end else begin
          regFile[ctlAddr] <= busIn[7:0];
        end
      end
      // Pins set as inputs land in control bits on each port clock
      for (int i = 0; i < 8; i++) begin
        if (pinMap[i][5]) begin
          ctrlReg[pinMap[i][4:3]][pinMap[i][2:0]] <= pinInSt[i];
        end
      end
    end
  end

  assign testPatternSetup = regFile[`ADP_REG_TEST_PATTERN];
  assign controlBits      = {ctrlReg[3], ctrlReg[2], ctrlReg[1], ctrlReg[0]};

  // Output pins follow their status bit with no port clock needed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link.ioPinOut <= 8'h00;
      link.ioPinOe  <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        link.ioPinOut[i] <= statusBits[pinMap[i][4:0]];
        link.ioPinOe[i]  <= ~pinMap[i][5];
      end
    end
  end

  // ****************************************
  // Ancillary packet intake, two-deep pipe
  // ****************************************
  assign ancIn   = (ancPhase == adp_pkg::AP_CKS && !hostSuppliesChecksum)
                   ? {~csum[8], csum} : busIn;
  assign pushNow = aclkRise && portReady && ancMode && pipe1V;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pipe0    <= 10'h000;
      pipe1    <= 10'h000;
      pipe0V   <= 1'b0;
      pipe1V   <= 1'b0;
      pipe0Did <= 1'b0;
      pipe1Did <= 1'b0;
      csum     <= 9'h000;
      udwLeft  <= 8'h00;
      ancPhase <= adp_pkg::AP_DID;
    end else if (!ancMode) begin
      pipe0V   <= 1'b0;
      pipe1V   <= 1'b0;
      ancPhase <= adp_pkg::AP_DID;
    end else if (aclkRise && portReady) begin
      pipe1    <= pipe0;
      pipe1V   <= pipe0V;
      pipe1Did <= pipe0Did;
      pipe0    <= ancIn;
      pipe0V   <= 1'b1;
      pipe0Did <= ancPhase == adp_pkg::AP_DID;
      case (ancPhase)
        adp_pkg::AP_DID: begin
          csum     <= busIn[8:0];
          ancPhase <= adp_pkg::AP_SDID;
        end
        adp_pkg::AP_SDID: begin
          csum     <= csum + busIn[8:0];
          ancPhase <= adp_pkg::AP_DC;
        end
        adp_pkg::AP_DC: begin
          csum     <= csum + busIn[8:0];
          udwLeft  <= busIn[7:0];
          ancPhase <= (busIn[7:0] == 8'h00) ? adp_pkg::AP_CKS : adp_pkg::AP_UDW;
        end
        adp_pkg::AP_UDW: begin
          csum    <= csum + busIn[8:0];
          udwLeft <= udwLeft - 8'h01;
          if (udwLeft == 8'h01) begin
            ancPhase <= adp_pkg::AP_CKS;
          end
        end
        default: begin
          ancPhase <= adp_pkg::AP_DID;
        end
      endcase
    end
  end

  // ****************************************
  // FIFO write side with flag prefix
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ancWord        <= 10'h000;
      ancValid       <= 1'b0;
      ancPacketStart <= 1'b0;
      pendWord       <= 10'h000;
      emitCnt        <= 3'h0;
    end else begin
      ancValid       <= 1'b0;
      ancPacketStart <= 1'b0;
      if (pushNow && pipe1Did) begin
        pendWord <= pipe1;
        emitCnt  <= 3'h4;
      end else if (pushNow) begin
        ancWord  <= pipe1;
        ancValid <= 1'b1;
      end else if (emitCnt != 3'h0) begin
        ancValid       <= 1'b1;
        ancPacketStart <= emitCnt == 3'h4;
        emitCnt        <= emitCnt - 3'h1;
        if (emitCnt == 3'h4) begin
          ancWord <= `ADP_FLAG_WORD0;
        end else if (emitCnt == 3'h1) begin
          ancWord <= pendWord;
        end else begin
          ancWord <= `ADP_FLAG_WORD1;
        end
      end
    end
  end
endmodule : adp_device
`default_nettype wire

/* hdl/adp_defines.svh */
// Constants shared by both ends of the ancillary/control data port
`ifndef ADP_DEFINES_SVH
`define ADP_DEFINES_SVH
// ****************************************
// Device register map
// ****************************************
`define ADP_REG_FIELD_FLAGS  8'h01
`define ADP_REG_TEST_PATTERN 8'h0d
`define ADP_REG_PIN_MAP0     8'h0f
`define ADP_REG_PIN_MAP_LAST 8'h16
`define ADP_REG_CTRL_BASE    8'h20
`define ADP_REG_CTRL_LAST    8'h23
`define ADP_PIN_MAP_RESET0   6'h00
// ****************************************
// Bus qualifiers and link sequencing
// ****************************************
`define ADP_QUAL_ADDR        2'h0
`define ADP_QUAL_WDATA       2'h3
`define ADP_QUAL_RDATA       2'h2
`define ADP_INIT_PULSES      2'h3
`define ADP_FLAG_WORD0       10'h000
`define ADP_FLAG_WORD1       10'h3ff
`define ADP_HBIT_PIN         2
// ****************************************
// Host command registers (APB)
// ****************************************
`define ADP_HOST_CMD         8'h00
`define ADP_HOST_STATUS      8'h04
`define ADP_SYS_PERIOD_NS    10
`define ADP_ACLK_HALF_NS     60
`define ADP_ACLK_HALF_CYC    (`ADP_ACLK_HALF_NS / `ADP_SYS_PERIOD_NS)
`endif

/* hdl/adp_pkg.sv */
// Types shared by both ends of the ancillary/control data port
package adp_pkg;
  typedef enum logic [1:0] {CS_IDLE, CS_WDATA, CS_DRIVE} adp_ctl_state_t;
  typedef enum logic [2:0] {AP_DID, AP_SDID, AP_DC, AP_UDW, AP_CKS} adp_anc_phase_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_HIGH} adp_host_state_t;
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_ANC, OP_FLUSH, OP_INIT} adp_host_op_t;
endpackage : adp_pkg

/* hdl/adp_link_if.sv */
// Link between host controller and device port
`timescale 1ns/1ps
`default_nettype none
interface adp_link_if;
  logic       aclk;
  logic       pathSelect;
  logic       readWriteSelect;
  logic [9:0] hostBus;
  logic       hostBusOe;
  logic [9:0] devBus;
  logic       devBusOe;
  logic [9:0] adBus;
  logic [7:0] ioPinOut;
  logic [7:0] ioPinOe;
  logic [7:0] ioPinLevel;
  // Shared bus with weak pull-down when nobody drives
  assign adBus      = hostBusOe ? hostBus : (devBusOe ? devBus : 10'h000);
  assign ioPinLevel = ioPinOut & ioPinOe;
  modport device (input aclk, pathSelect, readWriteSelect, adBus,
                  output devBus, devBusOe, ioPinOut, ioPinOe);
  modport host (output aclk, pathSelect, readWriteSelect, hostBus, hostBusOe,
                input adBus, ioPinLevel);
endinterface : adp_link_if
`default_nettype wire

/* hdl/adp_host.sv */
// Host controller end: APB command registers driving the port link
`include "adp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adp_host #(
  parameter int HALF = `ADP_ACLK_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  adp_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  adp_pkg::adp_host_state_t state;
  adp_pkg::adp_host_op_t    curOp;
  logic [7:0]  halfCnt;
  logic        tick;
  logic [9:0]  cmdData;
  logic [7:0]  cmdAddr;
  logic        cmdPending;
  logic        initDone;
  logic [7:0]  rdData;
  logic [1:0]  idx;
  logic [1:0]  lastIdx;
  logic [8:0]  syncA, syncB, syncC, inSt;
  logic        busy;

  assign busy = cmdPending || state != adp_pkg::HS_IDLE || !initDone;
  assign tick = halfCnt == 8'(HALF - 1);

  // ****************************************
  // Input synchroniser, change taken when stages two and three agree
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA <= 9'h000;
      syncB <= 9'h000;
      syncC <= 9'h000;
      inSt  <= 9'h000;
    end else begin
      syncA <= {link.ioPinLevel[`ADP_HBIT_PIN], link.adBus[7:0]};
      syncB <= syncA;
      syncC <= syncB;
      inSt  <= (syncB & syncC) | (inSt & (syncB | syncC));
    end
  end

  // Port clock divider
  always_ff @(posedge clk_sys) begin
    if (!rst_n || tick) begin
      halfCnt <= 8'h00;
    end else begin
      halfCnt <= halfCnt + 8'h01;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      cmdPending <= 1'b0;
      cmdData    <= 10'h000;
      cmdAddr    <= 8'h00;
      curOp      <= adp_pkg::OP_INIT;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        if (paddr == `ADP_HOST_CMD) begin
          prdata <= {11'h000, curOp, cmdAddr, cmdData};
        end else if (paddr == `ADP_HOST_STATUS) begin
          prdata <= {16'h0000, rdData, 5'h00, inSt[8], initDone, busy};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
      if (psel && penable && pready && pwrite && paddr == `ADP_HOST_CMD && !busy
          && pwdata[20:18] < 3'(adp_pkg::OP_INIT)) begin
        cmdData    <= pwdata[9:0];
        cmdAddr    <= pwdata[17:10];
        curOp      <= adp_pkg::adp_host_op_t'(pwdata[20:18]);
        cmdPending <= 1'b1;
      end else if (state == adp_pkg::HS_IDLE && cmdPending
                   && (curOp != adp_pkg::OP_ANC || inSt[8])) begin
        cmdPending <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state                <= adp_pkg::HS_SETUP;
      initDone             <= 1'b0;
      idx                  <= 2'h0;
      lastIdx              <= 2'(`ADP_INIT_PULSES - 2'h1);
      link.aclk            <= 1'b0;
      link.pathSelect      <= 1'b0;
      link.readWriteSelect <= 1'b0;
      link.hostBus         <= 10'h000;
      link.hostBusOe       <= 1'b0;
      rdData               <= 8'h00;
    end else begin
      case (state)
        adp_pkg::HS_IDLE: begin
          if (cmdPending && (curOp != adp_pkg::OP_ANC || inSt[8])) begin
            link.pathSelect      <= curOp == adp_pkg::OP_ANC || curOp == adp_pkg::OP_FLUSH;
            link.readWriteSelect <= curOp == adp_pkg::OP_READ;
            if (curOp == adp_pkg::OP_ANC) begin
              link.hostBus <= cmdData;
            end else begin
              link.hostBus <= {`ADP_QUAL_ADDR, cmdAddr};
            end
            link.hostBusOe <= curOp != adp_pkg::OP_FLUSH;
            lastIdx        <= (curOp == adp_pkg::OP_ANC) ? 2'h0 : 2'h1;
            idx            <= 2'h0;
            state          <= adp_pkg::HS_SETUP;
          end
        end
        adp_pkg::HS_SETUP: begin
          if (tick) begin
            link.aclk <= 1'b1;
            if (curOp == adp_pkg::OP_READ && idx == 2'h1) begin
              rdData <= inSt[7:0];
            end
            state <= adp_pkg::HS_HIGH;
          end
        end
        default: begin
          if (curOp == adp_pkg::OP_READ) begin
            link.hostBusOe <= 1'b0;
          end
          if (tick) begin
            link.aclk      <= 1'b0;
            link.hostBusOe <= 1'b0;
            if (idx == lastIdx) begin
              initDone <= 1'b1;
              state    <= adp_pkg::HS_IDLE;
              // Leave ancillary mode so the dummy flush words are dropped
              if (curOp == adp_pkg::OP_FLUSH) begin
                link.pathSelect <= 1'b0;
              end
            end else begin
              idx <= idx + 2'h1;
              if (curOp == adp_pkg::OP_WRITE) begin
                link.hostBus   <= {`ADP_QUAL_WDATA, cmdData[7:0]};
                link.hostBusOe <= 1'b1;
              end
              state <= adp_pkg::HS_SETUP;
            end
          end
        end
      endcase
    end
  end
endmodule : adp_host
`default_nettype wire

/* testbench/adp_link_assertions.sv */
// Checker for the link between host controller and device port
`timescale 1ns/1ps
`default_nettype none
module adp_link_assertions (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       aclk,
  input wire logic       pathSelect,
  input wire logic       readWriteSelect,
  input wire logic [9:0] hostBus,
  input wire logic       hostBusOe,
  input wire logic [9:0] devBus,
  input wire logic       devBusOe,
  input wire logic [9:0] adBus
);
  logic       aclkQ;
  logic [1:0] riseCnt;
  // Counts port clock rises since reset, saturating at three
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aclkQ   <= 1'b0;
      riseCnt <= 2'h0;
    end else begin
      aclkQ <= aclk;
      if (aclk && !aclkQ && riseCnt != 2'h3) begin
        riseCnt <= riseCnt + 2'h1;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd_addr;
    $rose(aclk) && hostBusOe && !pathSelect && readWriteSelect && hostBus[9:8] == 2'b00
      && riseCnt == 2'h3;
  endsequence
  sequence s_rd_release;
    $rose(aclk) && devBusOe;
  endsequence
  property p_rd_qual;
    devBusOe |-> devBus[9:8] == 2'b10;
  endproperty
  property p_bus_mux;
    devBusOe && !hostBusOe |-> adBus == devBus;
  endproperty
  property p_no_contend;
    hostBusOe |-> !devBusOe;
  endproperty
  property p_rd_mode;
    devBusOe |-> !pathSelect && readWriteSelect;
  endproperty
  property p_host_off;
    s_rd_addr |-> ##[1:2] !hostBusOe;
  endproperty
  property p_drive_start;
    s_rd_addr |-> ##[1:8] devBusOe;
  endproperty
  property p_drive_hold;
    devBusOe && $past(devBusOe) |-> $stable(devBus);
  endproperty
  property p_drive_end;
    s_rd_release |-> ##[2:6] !devBusOe;
  endproperty
  property p_end_at_rise;
    $fell(devBusOe) |-> aclk;
  endproperty
  property p_init;
    devBusOe |-> riseCnt == 2'h3;
  endproperty
  property p_wr_qual;
    hostBusOe && !pathSelect |-> hostBus[9:8] == 2'b00 || hostBus[9:8] == 2'b11;
  endproperty
  a_rd_qual: assert property (p_rd_qual) else $error("read qualifier wrong");
  a_bus_mux: assert property (p_bus_mux) else $error("bus not device data");
  a_no_contend: assert property (p_no_contend) else $error("bus contention");
  a_rd_mode: assert property (p_rd_mode) else $error("drive outside read");
  a_host_off: assert property (p_host_off) else $error("host kept bus");
  a_drive_start: assert property (p_drive_start) else $error("no read data");
  a_drive_hold: assert property (p_drive_hold) else $error("read data moved");
  a_drive_end: assert property (p_drive_end) else $error("bus not released");
  a_end_at_rise: assert property (p_end_at_rise) else $error("early release");
  a_init: assert property (p_init) else $error("drive before init");
  a_wr_qual: assert property (p_wr_qual) else $error("host qualifier wrong");
endmodule : adp_link_assertions
`default_nettype wire

/* testbench/tb_top.sv */
// Bench driving the host over APB and checking the device side
`include "adp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  fieldErrorFlags;
  logic [31:0] statusBits;
  logic [7:0]  ioPinIn;
  logic        hostSuppliesChecksum;
  logic [31:0] controlBits;
  logic [7:0]  testPatternSetup;
  logic [9:0]  ancWord;
  logic        ancValid;
  logic        ancPacketStart;
  logic [31:0] rd;
  logic [9:0]  got[$];
  logic [9:0]  pkt[5];
  logic [8:0]  sum;
  int          starts;
  int          errors;
  int          checks_done;
  adp_link_if i_adp_link_if ();
  adp_host i_adp_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_adp_link_if),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  adp_device i_adp_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_adp_link_if),
    .fieldErrorFlags(fieldErrorFlags), .statusBits(statusBits), .ioPinIn(ioPinIn),
    .hostSuppliesChecksum(hostSuppliesChecksum), .controlBits(controlBits),
    .testPatternSetup(testPatternSetup), .ancWord(ancWord), .ancValid(ancValid),
    .ancPacketStart(ancPacketStart));
  adp_link_assertions i_adp_link_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .aclk(i_adp_link_if.aclk), .pathSelect(i_adp_link_if.pathSelect),
    .readWriteSelect(i_adp_link_if.readWriteSelect), .hostBus(i_adp_link_if.hostBus),
    .hostBusOe(i_adp_link_if.hostBusOe), .devBus(i_adp_link_if.devBus),
    .devBusOe(i_adp_link_if.devBusOe), .adBus(i_adp_link_if.adBus));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // Flow of FIFO words out of the device
  always @(posedge clk_sys) begin
    if (ancValid === 1'b1) begin
      got.push_back(ancWord);
      if (ancPacketStart === 1'b1) begin
        starts++;
        chk(ancWord, 10'h000, "start not on flag");
      end
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Issues one link operation and waits until the host is idle again
  task automatic cmd(input adp_pkg::adp_host_op_t op, input logic [7:0] a,
                     input logic [9:0] w);
    int n;
    apb(1'b1, `ADP_HOST_CMD, {11'h000, op, a, w});
    n = 0;
    do begin
      apb(1'b0, `ADP_HOST_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      errors++;
      summarize();
    end
  endtask : cmd
  task automatic send_pkt(input logic [9:0] slot, input logic [9:0] exp);
    int n;
    got.delete();
    for (int i = 0; i < 5; i++) begin
      cmd(adp_pkg::OP_ANC, 8'h00, pkt[i]);
    end
    cmd(adp_pkg::OP_ANC, 8'h00, slot);
    cmd(adp_pkg::OP_FLUSH, 8'h00, 10'h000);
    n = 0;
    while (got.size() < 9 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk(got.size(), 9, "word count");
    chk(got[0], 10'h000, "flag 0");
    chk(got[1], 10'h3ff, "flag 1");
    chk(got[2], 10'h3ff, "flag 2");
    for (int i = 0; i < 5; i++) begin
      chk(got[3 + i], pkt[i], "packet word");
    end
    chk(got[8], exp, "checksum");
  endtask : send_pkt
  initial begin
    int n;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fieldErrorFlags = 8'h5a;
    statusBits = 32'h0000_0024;
    ioPinIn = 8'h00;
    hostSuppliesChecksum = 1'b0;
    pkt = '{10'h245, 10'h101, 10'h002, 10'h1aa, 10'h155};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, `ADP_HOST_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 100);
    chk(rd[1], 1'b1, "init not done");
    chk(i_adp_link_if.ioPinOe, 8'hff, "pin enables");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(pslverr, 1'b0, "slave error");
    apb(1'b1, `ADP_HOST_CMD, 32'h0010_0000);
    apb(1'b0, `ADP_HOST_STATUS, 32'h0);
    chk(rd[0], 1'b0, "bad op taken");
    cmd(adp_pkg::OP_READ, `ADP_REG_FIELD_FLAGS, 10'h000);
    chk(rd[15:8], 8'h5a, "flag read");
    cmd(adp_pkg::OP_WRITE, `ADP_REG_TEST_PATTERN, 10'h027);
    chk(testPatternSetup, 8'h27, "pattern write");
    apb(1'b0, `ADP_HOST_CMD, 32'h0);
    chk(rd, 32'h0004_3427, "command readback");
    cmd(adp_pkg::OP_READ, `ADP_REG_TEST_PATTERN, 10'h000);
    chk(rd[15:8], 8'h27, "pattern read");
    cmd(adp_pkg::OP_WRITE, `ADP_REG_FIELD_FLAGS, 10'h0ff);
    cmd(adp_pkg::OP_READ, `ADP_REG_FIELD_FLAGS, 10'h000);
    chk(rd[15:8], 8'h5a, "read-only written");
    for (int i = 0; i < 4; i++) begin
      cmd(adp_pkg::OP_WRITE, 8'(`ADP_REG_CTRL_BASE + i), {2'b00, 8'(8'h11 * (i + 1))});
    end
    chk(controlBits, 32'h4433_2211, "control regs");
    cmd(adp_pkg::OP_WRITE, `ADP_REG_PIN_MAP0, 10'h005);
    chk(i_adp_link_if.ioPinLevel[0], 1'b1, "pin out high");
    statusBits <= 32'h0000_0004;
    repeat (6) @(posedge clk_sys);
    chk(i_adp_link_if.ioPinLevel[0], 1'b0, "pin out low");
    cmd(adp_pkg::OP_READ, `ADP_REG_PIN_MAP0, 10'h000);
    chk(rd[15:8], 8'h05, "map read");
    cmd(adp_pkg::OP_WRITE, `ADP_REG_PIN_MAP_LAST, 10'h02b);
    ioPinIn <= 8'h80;
    repeat (10) @(posedge clk_sys);
    chk(controlBits[11], 1'b0, "pin in early");
    chk(i_adp_link_if.ioPinOe[7], 1'b0, "pin in enable");
    cmd(adp_pkg::OP_READ, `ADP_REG_FIELD_FLAGS, 10'h000);
    chk(controlBits[11], 1'b1, "pin in taken");
    sum = 9'h000;
    for (int i = 0; i < 5; i++) begin
      sum = sum + pkt[i][8:0];
    end
    send_pkt(10'h3c3, {~sum[8], sum});
    hostSuppliesChecksum <= 1'b1;
    send_pkt(10'h123, 10'h123);
    chk(starts, 2, "packet starts");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
